// *** rtl/wdtnr_apb.sv ***
// module: apb slave decode for the watchdog registers
`timescale 1ns/1ps
`default_nettype none
module wdtnr_apb
   import wdtnr_pkg::*;
(
   input wire wdtnr_apb_req_t req,
   input wire logic [31:0] mode_rdata,
   output logic pready,
   output logic pslverr,
   output logic mode_we,
   output logic code_we,
   output logic [31:0] rdata
);
   // access phase qualifier
   logic access;
   assign access = req.psel && req.penable;
   // zero wait state slave
   assign pready = 1'b1;
   // unmapped offsets answer with an error
   always_comb begin
      mode_we = 1'b0;
      code_we = 1'b0;
      pslverr = 1'b0;
      rdata = 32'h0;
      if (req.paddr == WDTNR_MODE_OFS) begin
         mode_we = access && req.pwrite;
         rdata = mode_rdata;
      end else if (req.paddr == WDTNR_CODE_OFS) begin
         code_we = access && req.pwrite;
      end else begin
         pslverr = access;
      end
   end
endmodule
`default_nettype wire

// *** rtl/wdtnr_expiry.sv ***
// module: selects the counter bit that marks expiry of the chosen period
`timescale 1ns/1ps
`default_nettype none
module wdtnr_expiry
   import wdtnr_pkg::*;
(
   input wire logic [WDTNR_CNT_W-1:0] count,
   input wire logic [2:0] period,
   output logic expired
);
   // one tap per legal period code
   logic [5:0] tap;
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_tap
         assign tap[g] = count[WDTNR_PERIOD_BASE + WDTNR_PERIOD_STEP * g];
      end
   endgenerate
   // prohibited codes never expire
   always_comb begin
      expired = 1'b0;
      if (period <= WDTNR_PERIOD_MAX) begin
         expired = tap[period];
      end
   end
endmodule
`default_nettype wire

// *** rtl/wdtnr_pkg.sv ***
// package: register map, codes and timing constants for the watchdog
package wdtnr_pkg;
   // register byte offsets
   localparam logic [11:0] WDTNR_MODE_OFS = 12'h000;
   localparam logic [11:0] WDTNR_CODE_OFS = 12'h004;
   // mode register field positions
   localparam int WDTNR_ENABLE_BIT = 7;
   localparam int WDTNR_PERIOD_LSB = 4;
   localparam int WDTNR_IDLE_BIT = 2;
   localparam int WDTNR_ACTION_BIT = 1;
   // reset values of mode fields
   localparam logic WDTNR_ENABLE_RST = 1'b1;
   localparam logic [2:0] WDTNR_PERIOD_RST = 3'h0;
   localparam logic WDTNR_IDLE_RST = 1'b0;
   localparam logic WDTNR_ACTION_RST = 1'b1;
   // command codes
   localparam logic [7:0] WDTNR_CLEAR_CODE = 8'h4e;
   localparam logic [7:0] WDTNR_DISABLE_CODE = 8'hb1;
   // counter width covers the longest period, 2^25
   localparam int WDTNR_CNT_W = 26;
   localparam logic [2:0] WDTNR_PERIOD_MAX = 3'h5;
   localparam int WDTNR_PERIOD_BASE = 15;
   localparam int WDTNR_PERIOD_STEP = 2;
   // reset hold length in system clock states
   localparam int WDTNR_RST_STATES = 32;
   localparam logic [5:0] WDTNR_RST_CYC = 6'(WDTNR_RST_STATES);
   // packed mode fields
   typedef struct packed {
      logic enable;
      logic [2:0] period;
      logic idle_run;
      logic action;
   } wdtnr_mode_t;
   // apb request bundle
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } wdtnr_apb_req_t;
endpackage

// *** rtl/wdtnr_top.sv ***
// module: watchdog timer with nmi or chip reset action and fault pin
`timescale 1ns/1ps
`default_nettype none
module wdtnr_top
   import wdtnr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic light_idle_mode,
   input wire logic debug_halt,
   output logic overflow_interrupt,
   output logic nmi_source_flag,
   output logic chip_reset_req,
   output logic clock_reinit_req,
   output logic fault_output_n
);
   ////////////////////////////////////////////////////////////////////////
   // state declarations
   wdtnr_mode_t mode_r, mode_nxt; // software mode fields
   logic active_r, active_nxt; // watchdog running (not disabled)
   logic [WDTNR_CNT_W-1:0] cnt_r, cnt_nxt; // binary counter
   logic fault_r, fault_nxt; // fault pin asserted
   logic nmi_r, nmi_nxt; // one-cycle nmi pulse
   logic flag_r, flag_nxt; // nmi source flag, sticky
   logic [5:0] rst_cnt_r, rst_cnt_nxt; // reset hold countdown
   logic [31:0] prdata_r, prdata_nxt; // registered read data
   ////////////////////////////////////////////////////////////////////////
   // bus slave
   wdtnr_apb_req_t req;
   logic mode_we, code_we;
   logic [31:0] mode_rdata, rdata_c;
   assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr,
                  pwdata: pwdata};
   // mode register image, reserved bits read zero
   // reserved read zero
   always_comb begin
      mode_rdata = 32'h0;
      mode_rdata[WDTNR_ENABLE_BIT] = mode_r.enable;
      mode_rdata[WDTNR_PERIOD_LSB +: 3] = mode_r.period;
      mode_rdata[WDTNR_IDLE_BIT] = mode_r.idle_run;
      mode_rdata[WDTNR_ACTION_BIT] = mode_r.action;
   end
   wdtnr_apb u_apb (
      .req(req),
      .mode_rdata(mode_rdata),
      .pready(pready),
      .pslverr(pslverr),
      .mode_we(mode_we),
      .code_we(code_we),
      .rdata(rdata_c)
   );
   // read data shows the register image captured on the previous clock of a read, zero otherwise
   assign prdata = prdata_r;
   ////////////////////////////////////////////////////////////////////////
   // expiry decode
   logic expired;
   wdtnr_expiry u_exp (
      .count(cnt_r),
      .period(mode_r.period),
      .expired(expired)
   );
   ////////////////////////////////////////////////////////////////////////
   // command decode
   logic [7:0] code;
   logic clear_cmd, disable_cmd, halted, running, overflow, in_reset;
   assign code = pwdata[7:0];
   assign clear_cmd = code_we && (code == WDTNR_CLEAR_CODE);
   // disable only with enable already zero
   assign disable_cmd = code_we && (code == WDTNR_DISABLE_CODE) && !mode_r.enable;
   // idle halt unless idle run set
   assign halted = debug_halt || (light_idle_mode && !mode_r.idle_run);
   assign running = active_r && !halted;
   assign in_reset = (rst_cnt_r != 6'h0);
   // overflow on first expiry bit reach
   assign overflow = running && expired && !fault_r && !in_reset;
   ////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      mode_nxt = mode_r;
      active_nxt = active_r;
      cnt_nxt = cnt_r;
      fault_nxt = fault_r;
      nmi_nxt = 1'b0;
      flag_nxt = flag_r;
      rst_cnt_nxt = rst_cnt_r;
      prdata_nxt = 32'h0;
      // register read capture
      if (psel && !pwrite) begin
         prdata_nxt = rdata_c;
      end
      // mode write, bit 0 ignored
      // bit 0 ignored
      if (mode_we) begin
         mode_nxt.enable = pwdata[WDTNR_ENABLE_BIT];
         mode_nxt.period = pwdata[WDTNR_PERIOD_LSB +: 3];
         mode_nxt.idle_run = pwdata[WDTNR_IDLE_BIT];
         mode_nxt.action = pwdata[WDTNR_ACTION_BIT];
         if (pwdata[WDTNR_ENABLE_BIT]) begin
            active_nxt = 1'b1;
         end
      end
      if (running && !fault_r) begin
         cnt_nxt = cnt_r + 1'b1;
      end
      // overflow response
      if (overflow) begin
         fault_nxt = 1'b1;
         if (mode_r.action) begin
            rst_cnt_nxt = WDTNR_RST_CYC;
         end else begin
            nmi_nxt = 1'b1;
            flag_nxt = 1'b1;
         end
      end
      // reset hold countdown, counter held at zero; counting resumes only after a clear code
      if (in_reset) begin
         rst_cnt_nxt = rst_cnt_r - 1'b1;
         cnt_nxt = '0;
      end
      if (clear_cmd) begin
         cnt_nxt = '0;
         // fault pin released, an overflow in the same cycle wins
         fault_nxt = overflow;
      end
      if (disable_cmd) begin
         active_nxt = 1'b0;
         cnt_nxt = '0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mode_r.enable <= WDTNR_ENABLE_RST;
         mode_r.period <= WDTNR_PERIOD_RST;
         mode_r.idle_run <= WDTNR_IDLE_RST;
         mode_r.action <= WDTNR_ACTION_RST;
         active_r <= WDTNR_ENABLE_RST;
         cnt_r <= '0;
         fault_r <= 1'b0;
         nmi_r <= 1'b0;
         flag_r <= 1'b0;
         rst_cnt_r <= 6'h0;
         prdata_r <= 32'h0;
      end else begin
         mode_r <= mode_nxt;
         active_r <= active_nxt;
         cnt_r <= cnt_nxt;
         fault_r <= fault_nxt;
         nmi_r <= nmi_nxt;
         flag_r <= flag_nxt;
         rst_cnt_r <= rst_cnt_nxt;
         prdata_r <= prdata_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign overflow_interrupt = nmi_r;
   assign nmi_source_flag = flag_r;
   assign chip_reset_req = in_reset;
   assign clock_reinit_req = in_reset;
   assign fault_output_n = !fault_r;
endmodule
`default_nettype wire

// *** test/test_wdtnr_top.sv ***
// testbench: registers, overflow actions and halts of the watchdog
`timescale 1ns/1ps
`default_nettype none
module test_wdtnr_top;
   import wdtnr_pkg::*;
   logic sys_clk, nrst, psel, penable, pwrite, light_idle_mode, debug_halt;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, overflow_interrupt, nmi_source_flag, chip_reset_req, fault_output_n;
   int err_count, comparisons, n, seed, nmi_count, rst_len, rnd;
   logic [32:0] expq[$]; // {pslverr, read data} notes
   wdtnr_top DUT (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .light_idle_mode(light_idle_mode), .debug_halt(debug_halt),
      .overflow_interrupt(overflow_interrupt), .nmi_source_flag(nmi_source_flag),
      .chip_reset_req(chip_reset_req), .clock_reinit_req(), .fault_output_n(fault_output_n));
   wdtnr_partner u_far (.sys_clk(sys_clk), .nrst(nrst), .overflow_interrupt(overflow_interrupt),
      .chip_reset_req(chip_reset_req), .nmi_count(nmi_count), .rst_len(rst_len));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // verdict and end of run
   task test_done;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task chk(input logic [32:0] s, input logic [32:0] e);
      comparisons++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   // one apb transfer, expectation noted
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      expq.push_back(e);
      @(posedge sys_clk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 50) begin
         err_count++;
         test_done;
      end
   endtask
   // bounded wait for a fault pin level
   task wait_fault(input logic lvl, input int lim);
      for (n = 0; n < lim && fault_output_n !== lvl; n++) cyc(1);
      if (n == lim) begin
         err_count++;
         test_done;
      end
   endtask
   // watcher: compares each finished transfer with oldest note
   always @(posedge sys_clk) begin
      if (nrst && psel && penable && pready === 1'b1 && expq.size() > 0)
         chk({pslverr, pwrite ? 32'h0 : prdata}, expq.pop_front());
   end
   initial begin
      seed = 4;
      {nrst, psel, penable, pwrite, light_idle_mode, debug_halt} = 6'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      cyc(20);
      nrst <= 1'b1;
      apb(1'b0, WDTNR_MODE_OFS, 32'h0, 33'h82);
      apb(1'b0, 12'h008, 32'h0, {1'b1, 32'h0});
      apb(1'b0, WDTNR_CODE_OFS, 32'h0, 33'h0);
      $display("register test done");
      // enable cleared alone keeps counting; disable code then stops and zeroes
      apb(1'b1, WDTNR_MODE_OFS, 32'h2, 33'h0);
      cyc(1000);
      apb(1'b1, WDTNR_CODE_OFS, {24'h0, WDTNR_DISABLE_CODE}, 33'h0);
      cyc(2000);
      apb(1'b0, WDTNR_MODE_OFS, 32'h0, 33'h2);
      // re-enable with idle run set, then sit in light idle
      apb(1'b1, WDTNR_MODE_OFS, 32'h86, 33'h0);
      light_idle_mode <= 1'b1;
      wait_fault(1'b0, 40000);
      light_idle_mode <= 1'b0;
      // a full shortest period from zero, so disable stopped and cleared it
      chk(33'(n > (1 << WDTNR_PERIOD_BASE) - 100
         && n < (1 << WDTNR_PERIOD_BASE) + 100), 33'h1);
      cyc(40);
      chk(33'(rst_len), 33'(WDTNR_RST_STATES));
      chk(33'(nmi_count), 33'h0);
      $display("disable and reset action test done");
      rnd = $random(seed);
      apb(1'b1, WDTNR_MODE_OFS, {rnd[31:8], 8'h81}, 33'h0);
      apb(1'b0, WDTNR_MODE_OFS, 32'h0, 33'h80);
      // software clear with random upper bits
      apb(1'b1, WDTNR_CODE_OFS, {rnd[23:0], WDTNR_CLEAR_CODE}, 33'h0);
      cyc(2);
      chk({32'h0, fault_output_n}, 33'h1);
      debug_halt <= 1'b1;
      cyc(1000);
      debug_halt <= 1'b0;
      light_idle_mode <= 1'b1;
      cyc(1000);
      light_idle_mode <= 1'b0;
      cyc(31000);
      chk({32'h0, fault_output_n}, 33'h1);
      // stray code and disable code while enabled must neither clear nor stop
      rnd = $random(seed);
      if (rnd[7:0] == WDTNR_CLEAR_CODE || rnd[7:0] == WDTNR_DISABLE_CODE) begin
         rnd[7:0] = 8'h00;
      end
      apb(1'b1, WDTNR_CODE_OFS, rnd, 33'h0);
      apb(1'b1, WDTNR_CODE_OFS, {24'h0, WDTNR_DISABLE_CODE}, 33'h0);
      wait_fault(1'b0, 3000);
      cyc(3);
      chk(33'(nmi_count), 33'h1);
      chk({32'h0, nmi_source_flag}, 33'h1);
      apb(1'b1, WDTNR_CODE_OFS, {24'h0, WDTNR_CLEAR_CODE}, 33'h0);
      cyc(2);
      chk({32'h0, fault_output_n}, 33'h1);
      chk(33'(expq.size()), 33'h0);
      $display("interrupt action test done");
      test_done;
   end
endmodule
`default_nettype wire

// *** test/wdtnr_asserts.sv ***
// checker: port level assertions for the watchdog
`timescale 1ns/1ps
`default_nettype none
module wdtnr_asserts
   import wdtnr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   input wire logic overflow_interrupt,
   input wire logic nmi_source_flag,
   input wire logic chip_reset_req,
   input wire logic clock_reinit_req,
   input wire logic fault_output_n
);
   logic clr; // clear code write taken
   logic [6:0] rcnt_r; // cycles of current chip reset
   logic [6:0] rcnt_nxt;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   assign clr = psel && penable && pwrite && paddr == WDTNR_CODE_OFS
      && pwdata[7:0] == WDTNR_CLEAR_CODE;
   // reset length counter
   always_comb rcnt_nxt = chip_reset_req ? rcnt_r + 7'h1 : 7'h0;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) rcnt_r <= 7'h0;
      else rcnt_r <= rcnt_nxt;
   end
   slverr_map_a: assert property (pslverr == (psel && penable
      && paddr != WDTNR_MODE_OFS && paddr != WDTNR_CODE_OFS)) else $error("bad pslverr");
   reinit_pair_a: assert property (clock_reinit_req == chip_reset_req)
      else $error("reinit differs");
   rst_len_a: assert property ($fell(chip_reset_req) |-> rcnt_r == 7'h20)
      else $error("reset length");
   irq_pulse_a: assert property (overflow_interrupt |=> !overflow_interrupt)
      else $error("irq not a pulse");
   irq_flag_a: assert property (overflow_interrupt |-> ##[0:1] nmi_source_flag)
      else $error("flag not set");
   flag_stick_a: assert property (nmi_source_flag |=> nmi_source_flag)
      else $error("flag dropped");
   irq_fault_a: assert property (overflow_interrupt |-> ##[0:1] !fault_output_n)
      else $error("fault pin high");
   fault_hold_a: assert property (!fault_output_n && !clr && !$past(clr) |=> !fault_output_n)
      else $error("fault released");
endmodule
bind wdtnr_top wdtnr_asserts u_chk (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
   .overflow_interrupt(overflow_interrupt), .nmi_source_flag(nmi_source_flag),
   .chip_reset_req(chip_reset_req), .clock_reinit_req(clock_reinit_req),
   .fault_output_n(fault_output_n));
`default_nettype wire

// *** test/wdtnr_partner.sv ***
// partner: processor nmi input and system reset logic
`timescale 1ns/1ps
`default_nettype none
module wdtnr_partner (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic overflow_interrupt,
   input wire logic chip_reset_req,
   output var int nmi_count,
   output var int rst_len
);
   int run_r; // cycles of reset seen so far
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         nmi_count <= 0;
         run_r <= 0;
         rst_len <= 0;
      end else begin
         if (overflow_interrupt) nmi_count <= nmi_count + 1;
         run_r <= chip_reset_req ? run_r + 1 : 0;
         if (chip_reset_req) rst_len <= run_r + 1;
      end
   end
endmodule
`default_nettype wire
